// ---- hw/epp_programmer.sv ----
/*
 Byte-wide EPROM programmer: drives chip select, output enable, program strobe,
 test-mode select, 13 address lines and 8 data lines of the target.
 Assumes the supply levels are switched outside; PPS_EN requests the high supply.
 Software uses a plain register port with read data one cycle after the read strobe.
*/
`include "epp_params.svh"
module epp_programmer
   import epp_pkg::*;
#(
   parameter int ADDR_W = 13,
   parameter int MAX_PRIME = `EPP_MAX_PRIME,
   parameter int PRIME_CYC = `EPP_PRIME_CYC,
   parameter int FINAL_CYC_PER_PRIME = `EPP_FINAL_CYC_PER_PRIME,
   parameter int SETUP_CYC = `EPP_SETUP_CYC,
   parameter int MAX_PROTECT = 4
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // software register port
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // target control pins
   output logic CHIP_SEL_N,
   output logic OUT_EN_N,
   output logic PROGRAM_STROBE_N,
   output logic TEST_MODE_SELECT,
   output logic PPS_EN,
   output logic [ADDR_W-1:0] BYTE_ADDRESS_LINES,
   // target data pins, three signals each
   input wire logic [7:0] BYTE_DATA_LINES_I,
   output logic [7:0] BYTE_DATA_LINES_O,
   output logic [7:0] BYTE_DATA_LINES_OE_N
);
   // synchronisers for reset and the data pins
   logic rst_s1_reg, rst_s2_reg;
   logic [7:0] din_s1_reg, din_s2_reg;
   // sequencer state and the latched request
   epp_state_t state_reg;
   epp_cmd_t cmd_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0] data_reg, rdata_reg;
   logic [4:0] prime_reg;
   logic [2:0] prot_try_reg;
   // status flags seen by software
   logic fail_reg, mism_reg, prot_reg, done_reg;
   // start decode and the final pulse length
   logic [31:0] final_cyc;
   logic go;
   epp_cmd_t go_cmd;
   epp_timer_if tif ();

   // one shared down counter times every interval; each state but final and done reloads it as it ends,
   // so a state lasts exactly the count it was loaded with
   epp_timer u_timer (
      .clk(CORE_CLK),
      .rst_n(rst_s2_reg),
      .t(tif)
   );

   // reset release through two flip-flops
   // assertion is immediate, release waits two edges so no flop leaves reset on a late edge
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // data pins come from outside the clock domain
   // the pins are only read inside windows that someone drives, so the two-clock lag is budgeted there
   always_ff @(posedge CORE_CLK or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         din_s1_reg <= 8'hFF;
         din_s2_reg <= 8'hFF;
      end else begin
         din_s1_reg <= BYTE_DATA_LINES_I;
         din_s2_reg <= din_s1_reg;
      end
   end

   // a command write starts a cycle; ignored while busy
   // codes five to seven are ignored, so a stray write cannot start an undefined cycle
   assign go_cmd = epp_cmd_t'(REG_WDATA[`EPP_CMD_LSB +: 3]);
   assign go = REG_WR && (REG_ADDR == `EPP_REG_CTRL) && (state_reg == EPP_IDLE)
               && (go_cmd != EPP_CMD_NONE) && (go_cmd <= EPP_CMD_PVERIFY);
   assign final_cyc = 32'(FINAL_CYC_PER_PRIME) * 32'(prime_reg);

   // address and data latches, writable only while idle so pins stay stable
   // software may program bytes in any order; each start takes whatever address is latched
   always_ff @(posedge CORE_CLK or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         addr_reg <= '0;
         data_reg <= 8'hFF;
      end else if (REG_WR && state_reg == EPP_IDLE) begin
         if (REG_ADDR == `EPP_REG_ADDR) addr_reg <= REG_WDATA[ADDR_W-1:0];
         if (REG_ADDR == `EPP_REG_DATA) data_reg <= REG_WDATA[7:0];
      end
   end

   // sequencer: setup, strobe, recover, verify, then final pulse or retry
   // state lengths in core clocks:
   //   setup    SETUP_CYC, address and data settle with the strobe high
   //   pulse    PRIME_CYC for program and protect, SETUP_CYC for read and protect verify
   //   recover  SETUP_CYC, strobe back high before output enable falls
   //   verify   SETUP_CYC with output enable low, sampled on its last clock
   //   final    FINAL_CYC_PER_PRIME times the prime pulses used
   //   done     one clock, raises the done flag
   // the sampled byte lags the pins by two clocks through the synchroniser, so
   // SETUP_CYC below four would sample the level before the target drives
   // a byte that never verifies stops after MAX_PRIME primes and is flagged failed
   // a protect cycle pulses up to MAX_PROTECT times in all while the bit still reads one
   always_ff @(posedge CORE_CLK or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         state_reg <= EPP_IDLE;
         cmd_reg <= EPP_CMD_NONE;
         prime_reg <= 5'h0;
         prot_try_reg <= 3'h0;
      end else begin
         unique case (state_reg)
            EPP_IDLE: begin
               if (go) begin
                  cmd_reg <= go_cmd;
                  prime_reg <= 5'h0;
                  prot_try_reg <= 3'h0;
                  state_reg <= EPP_SETUP;
               end
            end
            EPP_SETUP: begin
               // pins settle a setup time before any strobe
               if (tif.expired) state_reg <= EPP_PULSE;
            end
            EPP_PULSE: begin
               if (tif.expired) begin
                  if (cmd_reg == EPP_CMD_PROG) prime_reg <= prime_reg + 5'h1;
                  if (cmd_reg == EPP_CMD_PROTECT) prot_try_reg <= prot_try_reg + 3'h1;
                  state_reg <= (cmd_reg == EPP_CMD_PROG || cmd_reg == EPP_CMD_PROTECT)
                               ? EPP_RECOVER : EPP_DONE;
               end
            end
            EPP_RECOVER: begin
               if (tif.expired) state_reg <= EPP_VERIFY;
            end
            EPP_VERIFY: begin
               if (tif.expired) begin
                  if (cmd_reg == EPP_CMD_PROTECT) begin
                     // bit still one means unprotected: repeat
                     if (din_s2_reg[7] && prot_try_reg < 3'(MAX_PROTECT)) state_reg <= EPP_SETUP;
                     else state_reg <= EPP_DONE;
                  // a byte passes only when every bit equals the request, zeros and ones alike
                  end else if ((din_s2_reg | data_reg) == din_s2_reg && din_s2_reg == data_reg) begin
                     state_reg <= EPP_FINAL;
                  end else if (prime_reg < 5'(MAX_PRIME)) begin
                     state_reg <= EPP_SETUP;
                  end else begin
                     state_reg <= EPP_DONE;
                  end
               end
            end
            EPP_FINAL: begin
               if (tif.expired) state_reg <= EPP_DONE;
            end
            EPP_DONE: state_reg <= EPP_IDLE;
         endcase
      end
   end

   // timer loads on entry to each timed state, setup through final
   // each state reloads the timer as it expires, so the next state starts on a fresh count
   // final and done leave it alone; a start in idle loads the first setup interval
   always_comb begin
      tif.load = 1'b0;
      tif.count = 32'(SETUP_CYC);
      unique case (state_reg)
         EPP_IDLE: tif.load = go;
         EPP_SETUP: begin
            tif.load = tif.expired;
            tif.count = (cmd_reg == EPP_CMD_PROG || cmd_reg == EPP_CMD_PROTECT)
                        ? 32'(PRIME_CYC) : 32'(SETUP_CYC);
         end
         EPP_PULSE: tif.load = tif.expired;
         EPP_RECOVER: tif.load = tif.expired;
         EPP_VERIFY: begin
            tif.load = tif.expired;
            tif.count = 32'(SETUP_CYC);
            if (cmd_reg == EPP_CMD_PROG && din_s2_reg == data_reg) tif.count = final_cyc;
         end
         EPP_FINAL: tif.load = 1'b0;
         EPP_DONE: tif.load = 1'b0;
      endcase
   end

   // pin levels per mode; registered so every output comes from a flip-flop
   // command to pin levels:
   //   program         select low, enable high, strobe pulsed low, data driven, high supply
   //   program verify  select low, enable low, strobe high, data released
   //   read            select low, enable pulsed low, normal supply
   //   protect         select, enable, strobe and address bit 4 high, test select up, data bit 7 pulsed low
   //   protect verify  select low, enable pulsed low, address bit 6 low, test select up
   // forcing address bits here keeps the software address latch untouched
   always_ff @(posedge CORE_CLK or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         CHIP_SEL_N <= 1'b1;
         OUT_EN_N <= 1'b1;
         PROGRAM_STROBE_N <= 1'b1;
         TEST_MODE_SELECT <= 1'b0;
         PPS_EN <= 1'b0;
         BYTE_ADDRESS_LINES <= '0;
         BYTE_DATA_LINES_O <= 8'hFF;
         BYTE_DATA_LINES_OE_N <= 8'hFF;
      end else begin
         // inhibit by default: chip select and strobe high, outputs floating
         CHIP_SEL_N <= 1'b1;
         OUT_EN_N <= 1'b1;
         PROGRAM_STROBE_N <= 1'b1;
         TEST_MODE_SELECT <= 1'b0;
         PPS_EN <= 1'b0;
         BYTE_ADDRESS_LINES <= addr_reg;
         BYTE_DATA_LINES_O <= data_reg;
         BYTE_DATA_LINES_OE_N <= 8'hFF;
         if (state_reg != EPP_IDLE && state_reg != EPP_DONE) begin
            unique case (cmd_reg)
               EPP_CMD_PROG: begin
                  PPS_EN <= 1'b1;
                  CHIP_SEL_N <= 1'b0;
                  if (state_reg == EPP_VERIFY) begin
                     OUT_EN_N <= 1'b0;
                  end else begin
                     // zeros in data clear cells; ones leave them erased
                     BYTE_DATA_LINES_OE_N <= 8'h00;
                     PROGRAM_STROBE_N <= !(state_reg == EPP_PULSE || state_reg == EPP_FINAL);
                  end
               end
               EPP_CMD_READ: begin
                  CHIP_SEL_N <= 1'b0;
                  OUT_EN_N <= !(state_reg == EPP_PULSE);
               end
               EPP_CMD_PROTECT: begin
                  // supply up for the pulse; the protect bit is read back at the normal supply
                  PPS_EN <= (state_reg != EPP_VERIFY);
                  TEST_MODE_SELECT <= 1'b1;
                  if (state_reg == EPP_VERIFY) begin
                     CHIP_SEL_N <= 1'b0;
                     OUT_EN_N <= 1'b0;
                     BYTE_ADDRESS_LINES <= addr_reg & ~(ADDR_W'(1) << 6);
                  end else begin
                     BYTE_ADDRESS_LINES <= addr_reg | (ADDR_W'(1) << 4);
                     BYTE_DATA_LINES_OE_N <= 8'h7F;
                     BYTE_DATA_LINES_O <= {!(state_reg == EPP_PULSE), 7'h7F};
                  end
               end
               EPP_CMD_PVERIFY: begin
                  TEST_MODE_SELECT <= 1'b1;
                  CHIP_SEL_N <= 1'b0;
                  OUT_EN_N <= !(state_reg == EPP_PULSE);
                  BYTE_ADDRESS_LINES <= addr_reg & ~(ADDR_W'(1) << 6);
               end
               default: ;
            endcase
         end
      end
   end

   // result capture at the end of the sampling interval; set wins over a new start
   // a mismatch stays set until the next start, so software can tell that retries were needed
   // the protect flag follows every protect bit reading and is never cleared by a start
   always_ff @(posedge CORE_CLK or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         rdata_reg <= 8'hFF;
         fail_reg <= 1'b0;
         mism_reg <= 1'b0;
         prot_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         if (go) begin
            fail_reg <= 1'b0;
            mism_reg <= 1'b0;
            done_reg <= 1'b0;
         end
         if (state_reg == EPP_PULSE && tif.expired && (cmd_reg == EPP_CMD_READ || cmd_reg == EPP_CMD_PVERIFY)) begin
            rdata_reg <= din_s2_reg;
            if (cmd_reg == EPP_CMD_PVERIFY) prot_reg <= !din_s2_reg[7];
         end
         if (state_reg == EPP_VERIFY && tif.expired) begin
            rdata_reg <= din_s2_reg;
            if (cmd_reg == EPP_CMD_PROTECT) prot_reg <= !din_s2_reg[7];
            if (cmd_reg == EPP_CMD_PROG && din_s2_reg != data_reg) begin
               mism_reg <= 1'b1;
               if (prime_reg >= 5'(MAX_PRIME)) fail_reg <= 1'b1;
            end
            if (cmd_reg == EPP_CMD_PROTECT && din_s2_reg[7] && prot_try_reg >= 3'(MAX_PROTECT)) fail_reg <= 1'b1;
         end
         if (state_reg == EPP_DONE) done_reg <= 1'b1;
      end
   end

   // register read port, data one cycle after the strobe
   // data stand one cycle only and read zero otherwise, so a stale value is never taken for an answer
   always_ff @(posedge CORE_CLK or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         REG_RDATA <= 32'h0;
      end else if (REG_RD) begin
         unique case (REG_ADDR)
            `EPP_REG_CTRL: REG_RDATA <= {29'h0, cmd_reg};
            `EPP_REG_ADDR: REG_RDATA <= 32'(addr_reg);
            `EPP_REG_DATA: REG_RDATA <= {24'h0, data_reg};
            `EPP_REG_STAT: REG_RDATA <= {19'h0, prime_reg, 3'h0, done_reg, prot_reg, mism_reg, fail_reg,
                                         (state_reg != EPP_IDLE)};
            `EPP_REG_RDATA: REG_RDATA <= {24'h0, rdata_reg};
            default: REG_RDATA <= 32'h0;
         endcase
      end else begin
         REG_RDATA <= 32'h0;
      end
   end
endmodule : epp_programmer

// ---- hw/epp_params.svh ----
/*
 Holds the timing counts, register offsets and field positions of the programming controller.
 Assumes a 250 MHz core clock; included by bare name.
*/
`ifndef EPP_PARAMS_SVH
`define EPP_PARAMS_SVH
`define EPP_CLK_MHZ 250
`define EPP_PRIME_US 1000
`define EPP_FINAL_US_PER_PRIME 4000
`define EPP_PRIME_CYC (`EPP_PRIME_US * `EPP_CLK_MHZ)
`define EPP_FINAL_CYC_PER_PRIME (`EPP_FINAL_US_PER_PRIME * `EPP_CLK_MHZ)
`define EPP_SETUP_NS 100
`define EPP_SETUP_CYC ((`EPP_SETUP_NS * `EPP_CLK_MHZ + 999) / 1000)
`define EPP_MAX_PRIME 15
`define EPP_REG_CTRL 4'h0
`define EPP_REG_ADDR 4'h1
`define EPP_REG_DATA 4'h2
`define EPP_REG_STAT 4'h3
`define EPP_REG_RDATA 4'h4
`define EPP_CMD_LSB 0
`define EPP_STAT_BUSY 0
`define EPP_STAT_FAIL 1
`define EPP_STAT_MISM 2
`define EPP_STAT_PROT 3
`define EPP_STAT_DONE 4
`endif

// ---- hw/epp_pkg.sv ----
/*
 Types shared by the programming controller files.
 Assumes the params header is available.
*/
package epp_pkg;
   typedef enum logic [2:0] {
      EPP_CMD_NONE, EPP_CMD_PROG, EPP_CMD_READ, EPP_CMD_PROTECT, EPP_CMD_PVERIFY
   } epp_cmd_t;
   typedef enum {
      EPP_IDLE, EPP_SETUP, EPP_PULSE, EPP_RECOVER, EPP_VERIFY, EPP_FINAL, EPP_DONE
   } epp_state_t;
endpackage : epp_pkg

// ---- hw/epp_timer_if.sv ----
/*
 Carries the load and expiry of the pulse timer between controller and timer.
 Assumes one clock domain.
*/
interface epp_timer_if;
   logic load;
   logic [31:0] count;
   logic expired;
   modport ctrl (output load, output count, input expired);
   modport tmr (input load, input count, output expired);
endinterface : epp_timer_if

// ---- hw/epp_timer.sv ----
/*
 Down counter that times strobe pulses and setup gaps.
 Assumes load is a one-cycle pulse; expired is a level while idle at zero.
*/
module epp_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   epp_timer_if.tmr t
);
   logic [31:0] cnt_reg;
   // load wins over counting so a new interval never merges with the last
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 32'h0;
      end else if (t.load) begin
         // loaded one below the length: the zero count is the last clock of the interval
         cnt_reg <= (t.count != 32'h0) ? t.count - 32'h1 : 32'h0;
      end else if (cnt_reg != 32'h0) begin
         cnt_reg <= cnt_reg - 32'h1;
      end
   end
   // expiry must not look at load: the controller derives load from expiry
   assign t.expired = (cnt_reg == 32'h0);
endmodule : epp_timer

// ---- verification/epp_programmer_chk.sv ----
/*
 Checker for the programming controller: watches only the top module's pins.
 Assumes one clock domain and the reset port as the disable condition.
*/
module epp_programmer_chk #(
   parameter int MAX_PRIME = 15,
   parameter int PRIME_CYC = 20,
   parameter int FINAL_CYC_PER_PRIME = 80
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // register port
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   // target pins
   input wire logic CHIP_SEL_N,
   input wire logic OUT_EN_N,
   input wire logic PROGRAM_STROBE_N,
   input wire logic TEST_MODE_SELECT,
   input wire logic PPS_EN,
   input wire logic [12:0] BYTE_ADDRESS_LINES,
   input wire logic [7:0] BYTE_DATA_LINES_O,
   input wire logic [7:0] BYTE_DATA_LINES_OE_N
);
   int low_cnt;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // length of the current strobe-low run, so pulse widths can be judged at the rising edge
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) low_cnt <= 0;
      else if (!PROGRAM_STROBE_N) low_cnt <= low_cnt + 1;
      else low_cnt <= 0;
   end
   property p_setup;
      $fell(PROGRAM_STROBE_N) |-> $stable(BYTE_ADDRESS_LINES) && $stable(BYTE_DATA_LINES_O);
   endproperty
   a_setup: assert property (p_setup) else $error("address or data moved as strobe fell");
   property p_prog_mode;
      !PROGRAM_STROBE_N |-> !CHIP_SEL_N && OUT_EN_N && PPS_EN && BYTE_DATA_LINES_OE_N == 8'h00;
   endproperty
   a_prog_mode: assert property (p_prog_mode) else $error("strobe low outside program levels");
   property p_pulse_len;
      $rose(PROGRAM_STROBE_N) |-> low_cnt == PRIME_CYC || (low_cnt % FINAL_CYC_PER_PRIME == 0 &&
         low_cnt > 0 && low_cnt <= FINAL_CYC_PER_PRIME * MAX_PRIME);
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("strobe pulse of wrong length");
   property p_verify_follow;
      $rose(PROGRAM_STROBE_N) && low_cnt == PRIME_CYC |-> ##[1:40] !OUT_EN_N;
   endproperty
   a_verify_follow: assert property (p_verify_follow) else $error("no verify after prime pulse");
   property p_prime_max;
      $past(REG_RD) && $past(REG_ADDR) == 4'h3 |-> REG_RDATA[12:8] <= MAX_PRIME;
   endproperty
   a_prime_max: assert property (p_prime_max) else $error("prime count above maximum");
   property p_verify_mode;
      !OUT_EN_N |-> !CHIP_SEL_N && PROGRAM_STROBE_N && BYTE_DATA_LINES_OE_N == 8'hFF;
   endproperty
   a_verify_mode: assert property (p_verify_mode) else $error("output enable low with bad levels");
   property p_protect;
      TEST_MODE_SELECT && !BYTE_DATA_LINES_OE_N[7] |-> CHIP_SEL_N && OUT_EN_N && PROGRAM_STROBE_N &&
         BYTE_ADDRESS_LINES[4] && PPS_EN;
   endproperty
   a_protect: assert property (p_protect) else $error("protect cycle levels wrong");
   property p_pverify;
      TEST_MODE_SELECT && !OUT_EN_N |-> !BYTE_ADDRESS_LINES[6] && !CHIP_SEL_N && PROGRAM_STROBE_N;
   endproperty
   a_pverify: assert property (p_pverify) else $error("protect verify levels wrong");
   // main scenarios reached
   c_pulse: cover property ($rose(PROGRAM_STROBE_N));
   c_protect: cover property (TEST_MODE_SELECT && !BYTE_DATA_LINES_O[7] && !BYTE_DATA_LINES_OE_N[7]);
   c_pverify: cover property (TEST_MODE_SELECT && !OUT_EN_N);
endmodule : epp_programmer_chk

// ---- verification/epp_eprom_model.sv ----
/*
 Behavioural model of the byte-wide EPROM with its protect cell.
 Assumes the controller's pins change on the core clock; need_pulses sets how many primes a byte takes.
*/
module epp_eprom_model (
   // clock
   input wire logic clk,
   // control pins
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic strobe_n,
   input wire logic tms,
   input wire logic pps,
   input wire logic [12:0] addr,
   // data pins of the controller and scenario knob
   input wire logic [7:0] d_o,
   input wire logic [7:0] d_oe_n,
   input wire logic [7:0] need_pulses,
   output logic [7:0] bus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:8191];
   logic prot_bit;
   logic [7:0] last;
   logic [7:0] dq;
   logic dev_en;
   logic strobe_q;
   logic [12:0] addr_q;
   logic [7:0] pulses;
   // erased state: every cell and the protect bit at one
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
      prot_bit = 1'b1;
      last = 8'h00;
      strobe_q = 1'b1;
      addr_q = 13'h0000;
      pulses = 8'h00;
   end
   // output drive; a protected array answers with all ones, never its contents
   always_comb begin
      dev_en = 1'b0;
      dq = 8'hFF;
      if (!cs_n && !oe_n && strobe_n) begin
         dev_en = 1'b1;
         if (tms && !addr[6]) dq = {prot_bit, 7'h7F};
         else if (prot_bit) dq = mem[addr];
      end
   end
   // undriven bits show the inverse of their last level, so stale data never looks valid
   always_comb begin
      for (int i = 0; i < 8; i++)
         bus[i] = !d_oe_n[i] ? d_o[i] : (dev_en ? dq[i] : ~last[i]);
   end
   // programming counts falling strobes at one address; cells only go from one to zero
   always @(posedge clk) begin
      last <= bus;
      strobe_q <= strobe_n;
      addr_q <= addr;
      if (addr != addr_q) pulses <= 8'h00;
      else if (strobe_q && !strobe_n && !cs_n && oe_n && pps) begin
         pulses <= pulses + 8'h01;
         if (pulses + 8'h01 >= need_pulses) mem[addr] <= mem[addr] & bus;
      end
      // protect cell is only ever cleared, never set back
      if (cs_n && oe_n && strobe_n && addr[4] && tms && pps && !bus[7]) prot_bit <= 1'b0;
   end
endmodule : epp_eprom_model

// ---- verification/test_eprom_program_protect_port.sv ----
/*
 Self-checking bench for the programming controller with a model of the EPROM.
 Assumes shortened pulse counts; the register port is driven right after rising edges.
*/
`include "epp_params.svh"
module test_eprom_program_protect_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [3:0] REG_ADDR = 4'h0;
   logic [31:0] REG_WDATA = 32'h0;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [31:0] REG_RDATA;
   logic CHIP_SEL_N, OUT_EN_N, PROGRAM_STROBE_N, TEST_MODE_SELECT, PPS_EN;
   logic [12:0] BYTE_ADDRESS_LINES;
   logic [7:0] BYTE_DATA_LINES_I, BYTE_DATA_LINES_O, BYTE_DATA_LINES_OE_N;
   logic [7:0] need = 8'h01;
   logic [31:0] st, rv;
   int num_errors = 0, checks_done = 0, cyc = 0, run = 0, last_low = 0;
   epp_programmer #(.PRIME_CYC(20), .FINAL_CYC_PER_PRIME(80), .SETUP_CYC(4)) u_epp_programmer (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CHIP_SEL_N(CHIP_SEL_N), .OUT_EN_N(OUT_EN_N),
      .PROGRAM_STROBE_N(PROGRAM_STROBE_N), .TEST_MODE_SELECT(TEST_MODE_SELECT), .PPS_EN(PPS_EN),
      .BYTE_ADDRESS_LINES(BYTE_ADDRESS_LINES), .BYTE_DATA_LINES_I(BYTE_DATA_LINES_I),
      .BYTE_DATA_LINES_O(BYTE_DATA_LINES_O), .BYTE_DATA_LINES_OE_N(BYTE_DATA_LINES_OE_N));
   epp_eprom_model u_epp_eprom_model (.clk(CORE_CLK), .cs_n(CHIP_SEL_N), .oe_n(OUT_EN_N),
      .strobe_n(PROGRAM_STROBE_N), .tms(TEST_MODE_SELECT), .pps(PPS_EN), .addr(BYTE_ADDRESS_LINES),
      .d_o(BYTE_DATA_LINES_O), .d_oe_n(BYTE_DATA_LINES_OE_N), .need_pulses(need), .bus(BYTE_DATA_LINES_I));
   initial forever #2 CORE_CLK = ~CORE_CLK;
   // strobe-low run length, kept for the final pulse check; also the hang guard
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (!PROGRAM_STROBE_N) run <= run + 1;
      else if (run != 0) begin
         last_low <= run;
         run <= 0;
      end
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge CORE_CLK);
      REG_RD <= 1'b1; REG_ADDR <= a;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask : rd
   // issue a command and poll status until busy drops, bounded
   task automatic run_cmd(input logic [2:0] cmd);
      wr(`EPP_REG_CTRL, {29'h0, cmd});
      for (int i = 0; i < 3000; i++) begin
         rd(`EPP_REG_STAT, st);
         if (st[`EPP_STAT_BUSY] === 1'b0) break;
      end
      check({31'h0, st[`EPP_STAT_DONE]}, 32'h1);
   endtask : run_cmd
   task automatic t_read(input logic [12:0] a, input logic [7:0] exp);
      wr(`EPP_REG_ADDR, {19'h0, a});
      run_cmd(3'h2);
      rd(`EPP_REG_RDATA, rv);
      check({24'h0, rv[7:0]}, {24'h0, exp});
   endtask : t_read
   task automatic t_prog(input logic [12:0] a, input logic [7:0] d, input logic [7:0] n,
                         input int primes, input logic [7:0] exp);
      need <= n;
      wr(`EPP_REG_ADDR, {19'h0, a});
      wr(`EPP_REG_DATA, {24'h0, d});
      run_cmd(3'h1);
      check({27'h0, st[12:8]}, primes);
      check({31'h0, st[`EPP_STAT_FAIL]}, {31'h0, exp != d});
      check({31'h0, st[`EPP_STAT_MISM]}, {31'h0, primes > 1});
      if (exp == d) check(last_low, 80 * primes);
      else check(last_low, 20);
      t_read(a, exp);
   endtask : t_prog
   // protect, verify the protect bit, then see the array blocked
   task automatic t_protect();
      run_cmd(3'h3);
      check({31'h0, st[`EPP_STAT_PROT]}, 32'h1);
      run_cmd(3'h4);
      rd(`EPP_REG_RDATA, rv);
      check({31'h0, rv[7]}, 32'h0);
      t_read(13'h1ABC, 8'hFF);
   endtask : t_protect
   initial begin
      repeat (5) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      rd(4'hF, rv);
      check(rv, 32'h0);
      t_read(13'h1FFF, 8'hFF);
      t_prog(13'h1ABC, 8'hA5, 8'h01, 1, 8'hA5);
      t_prog(13'h0010, 8'h3C, 8'h03, 3, 8'h3C);
      t_prog(13'h1ABC, 8'h0F, 8'h01, 15, 8'h05);
      t_prog(13'h0123, 8'h00, 8'h63, 15, 8'hFF);
      t_prog(13'h0200, 8'h12, 8'h01, 1, 8'h12);
      t_prog(13'h0201, 8'h34, 8'h02, 2, 8'h34);
      t_protect();
      end_sim();
   end
endmodule : test_eprom_program_protect_port
bind epp_programmer epp_programmer_chk #(.MAX_PRIME(MAX_PRIME), .PRIME_CYC(PRIME_CYC),
   .FINAL_CYC_PER_PRIME(FINAL_CYC_PER_PRIME)) u_epp_programmer_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CHIP_SEL_N(CHIP_SEL_N),
   .OUT_EN_N(OUT_EN_N), .PROGRAM_STROBE_N(PROGRAM_STROBE_N), .TEST_MODE_SELECT(TEST_MODE_SELECT),
   .PPS_EN(PPS_EN), .BYTE_ADDRESS_LINES(BYTE_ADDRESS_LINES), .BYTE_DATA_LINES_O(BYTE_DATA_LINES_O),
   .BYTE_DATA_LINES_OE_N(BYTE_DATA_LINES_OE_N));
